/* File: src/tsp_regs.svh */
// Register offsets, field positions, reset values and line constants of the serial port.
`ifndef TSP_REGS_SVH
`define TSP_REGS_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define TSP_CTRL_OFS 12'h000
`define TSP_RATE_OFS 12'h004
`define TSP_TXDATA_OFS 12'h008
`define TSP_RXDATA_OFS 12'h00c
`define TSP_STATUS_OFS 12'h010
// ****************************************
// Control register fields
// ****************************************
`define TSP_CTRL_DATA8 0
`define TSP_CTRL_BIT8VAL 1
`define TSP_CTRL_CHKEN 2
`define TSP_CTRL_ODD 3
`define TSP_CTRL_STOP2 4
`define TSP_CTRL_HALF 5
`define TSP_CTRL_LOCAL 6
`define TSP_CTRL_FDXMDM 7
`define TSP_CTRL_HDXMDM 8
`define TSP_CTRL_CODE 9
`define TSP_CTRL_ETX 10
`define TSP_CTRL_EOT 11
`define TSP_CTRL_W 12
`define TSP_CTRL_RST 12'h000
// ****************************************
// Status register fields
// ****************************************
`define TSP_ST_RXVALID 0
`define TSP_ST_PARERR 1
`define TSP_ST_FRMERR 2
`define TSP_ST_TXPEND 3
`define TSP_ST_TXBUSY 4
`define TSP_ST_OWN 5
`define TSP_ST_RTS 6
// ****************************************
// Rates, reset value and codes
// ****************************************
`define TSP_RATE_N 11
`define TSP_RATE_RST 11'h008
`define TSP_CLK_HZ 100000000
`define TSP_BAUD_LIST {32'd19200, 32'd9600, 32'd4800, 32'd2400, 32'd1800, 32'd1200, \
   32'd600, 32'd300, 32'd150, 32'd110, 32'd75}
`define TSP_ETX 8'h03
`define TSP_EOT 8'h04
`endif

/* File: src/tsp_pkg.sv */
// Types shared by the serial port design and its bench.
package tsp_pkg;
   typedef logic [11:0] tsp_addr_t;
   typedef logic [31:0] tsp_word_t;
   typedef enum logic [1:0] {
      TSP_TX_IDLE = 2'b01,
      TSP_TX_SHIFT = 2'b10
   } tsp_tx_state_t;
   typedef enum logic [2:0] {
      TSP_RX_IDLE = 3'b001,
      TSP_RX_START = 3'b010,
      TSP_RX_BITS = 3'b100
   } tsp_rx_state_t;
endpackage

/* File: src/tsp_serial_port.sv */
// Asynchronous serial port with APB configuration, turnaround and local echo.
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "tsp_regs.svh"
// How it works
// - Data width setting selects seven or eight data bits per character.
// - In eight-bit mode bit eight of each sent character is forced to the set value.
// - With check bit enabled a parity bit follows the data word.
// - With check bit off the first stop bit follows the data directly.
// - Parity sense selects odd or even, only when check bit enabled.
// - Stop count setting appends one or two stop bits.
// - One rate setting drives both transmit and receive timing.
// - Direct connect raises request-to-send for each character only.
// - Full-duplex modem holds request-to-send high continuously.
// - No connection method selected keeps request-to-send low.
// - Half-duplex modem mode turns the line around between directions.
// - Turnaround method applies only in half-duplex modem mode; secondary uses side channel.
// - Code turnaround flips direction on the ETX or EOT character.
// - Half duplex loops each sent character back into the receiver, except when a received character completes in the same cycle.
// - Full duplex never loops sent characters back.
// - Each frame starts with one start bit; nine to twelve bits total.
// - Eleven rates from 75 to 19200 baud are selectable.
module tsp_serial_port #(
   parameter int CLK_HZ = `TSP_CLK_HZ
) (
   // Clock, reset, enable
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire tsp_pkg::tsp_addr_t paddr_in,
   input wire tsp_pkg::tsp_word_t pwdata_in,
   output tsp_pkg::tsp_word_t prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Serial line and modem control
   input wire logic rxd_in,
   input wire logic sec_rx_in,
   output logic txd_out,
   output logic rts_out,
   output logic sec_tx_out
);
   import tsp_pkg::*;
   // ****************************************
   // Functions
   // ****************************************
   localparam logic [32*`TSP_RATE_N-1:0] BAUDS = `TSP_BAUD_LIST;
   // Bit period in clocks; a rate word with several bits set uses the highest bit set, and a word with no bit set gives 75 baud.
   function automatic logic [31:0] bit_clks(input logic [`TSP_RATE_N-1:0] sel);
      logic [31:0] d;
      d = 32'(CLK_HZ / 75);
      for (int i = 0; i < `TSP_RATE_N; i++) begin
         if (sel[i]) begin
            d = 32'(CLK_HZ / int'(BAUDS[32*i +: 32]));
         end
      end
      return d;
   endfunction

   // Data bits after the 7-bit base, with forced bit eight in the top position.
   function automatic logic [7:0] word_of(input logic [7:0] d, input logic [11:0] c);
      return {c[`TSP_CTRL_DATA8] & c[`TSP_CTRL_BIT8VAL], d[6:0]};
   endfunction

   function automatic logic par_of(input logic [7:0] w, input logic [11:0] c);
      return (^w) ^ c[`TSP_CTRL_ODD];
   endfunction

   // Frame length without the second stop bit.
   function automatic logic [3:0] frame_len(input logic [11:0] c);
      return 4'(4'd9 + {3'd0, c[`TSP_CTRL_DATA8]} + {3'd0, c[`TSP_CTRL_CHKEN]});
   endfunction

   // ****************************************
   // Registers and APB access
   // ****************************************
   logic [`TSP_CTRL_W-1:0] ctrl;
   logic [`TSP_RATE_N-1:0] rate;
   logic [7:0] tx_hold;
   logic tx_pend;
   logic [7:0] rx_data;
   logic rx_valid;
   logic par_err;
   logic frm_err;
   logic line_own;
   logic acc;
   logic wr;
   logic rd_rx;
   logic mapped;
   logic tx_start;
   logic tx_done;
   logic rx_done;
   logic [7:0] rx_word;
   logic rx_perr;
   logic rx_ferr;
   tsp_tx_state_t tx_state;

   assign acc = psel_in & penable_in & ce_in;
   assign wr = acc & pwrite_in;
   assign rd_rx = acc & ~pwrite_in & (paddr_in == `TSP_RXDATA_OFS);
   assign mapped = (paddr_in == `TSP_CTRL_OFS) | (paddr_in == `TSP_RATE_OFS) |
                   (paddr_in == `TSP_TXDATA_OFS) | (paddr_in == `TSP_RXDATA_OFS) |
                   (paddr_in == `TSP_STATUS_OFS);
   assign pready_out = acc;
   assign pslverr_out = acc & ~mapped;
   always_comb begin
      prdata_out = 32'h0000_0000;
      unique case (paddr_in)
         `TSP_CTRL_OFS: prdata_out = {20'h00000, ctrl};
         `TSP_RATE_OFS: prdata_out = {21'h000000, rate};
         `TSP_TXDATA_OFS: prdata_out = {24'h000000, tx_hold};
         `TSP_RXDATA_OFS: prdata_out = {24'h000000, rx_data};
         `TSP_STATUS_OFS: prdata_out = {25'h0000000, rts_out, line_own,
                                        tx_state == TSP_TX_SHIFT, tx_pend,
                                        frm_err, par_err, rx_valid};
         default: prdata_out = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctrl <= `TSP_CTRL_RST;
         rate <= `TSP_RATE_RST;
      end else if (wr && paddr_in == `TSP_CTRL_OFS) begin
         ctrl <= pwdata_in[`TSP_CTRL_W-1:0];
      end else if (wr && paddr_in == `TSP_RATE_OFS) begin
         rate <= pwdata_in[`TSP_RATE_N-1:0];
      end
   end
   // A write while a character is still pending is dropped; poll the pending bit first.
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tx_hold <= 8'h00;
         tx_pend <= 1'b0;
      end else if (ce_in) begin
         if (tx_start) begin
            tx_pend <= 1'b0;
         end else if (wr && paddr_in == `TSP_TXDATA_OFS && !tx_pend) begin
            tx_hold <= pwdata_in[7:0];
            tx_pend <= 1'b1;
         end
      end
   end

   // ****************************************
   // Line direction
   // ****************************************
   logic sec_m;
   logic sec_s;
   logic hdx_mdm;
   logic [7:0] tx_char;
   logic turn_tx;
   logic turn_rx;

   assign hdx_mdm = ctrl[`TSP_CTRL_HDXMDM];
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sec_m <= 1'b0;
         sec_s <= 1'b0;
      end else if (ce_in) begin
         sec_m <= sec_rx_in;
         sec_s <= sec_m;
      end
   end

   assign turn_tx = (ctrl[`TSP_CTRL_ETX] && tx_char[6:0] == `TSP_ETX) ||
                    (ctrl[`TSP_CTRL_EOT] && tx_char[6:0] == `TSP_EOT);
   assign turn_rx = (ctrl[`TSP_CTRL_ETX] && rx_word[6:0] == `TSP_ETX) ||
                    (ctrl[`TSP_CTRL_EOT] && rx_word[6:0] == `TSP_EOT);
   // Outside half-duplex modem mode the terminal always owns the line.
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         line_own <= 1'b1;
      end else if (ce_in) begin
         if (!hdx_mdm) begin
            line_own <= 1'b1;
         end else if (!ctrl[`TSP_CTRL_CODE]) begin
            line_own <= ~sec_s;
         end else if (tx_done && turn_tx) begin
            line_own <= 1'b0;
         end else if (rx_done && turn_rx) begin
            line_own <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rts_out <= 1'b0;
         sec_tx_out <= 1'b0;
      end else if (ce_in) begin
         sec_tx_out <= hdx_mdm & ~ctrl[`TSP_CTRL_CODE] & ~line_own;
         if (ctrl[`TSP_CTRL_LOCAL]) begin
            rts_out <= tx_start | (tx_state == TSP_TX_SHIFT && !tx_done);
         end else if (ctrl[`TSP_CTRL_FDXMDM]) begin
            rts_out <= 1'b1;
         end else if (hdx_mdm) begin
            rts_out <= line_own;
         end else begin
            rts_out <= 1'b0;
         end
      end
   end

   // ****************************************
   // Transmitter
   // ****************************************
   logic [11:0] tx_sh;
   logic [3:0] tx_left;
   logic [31:0] tx_cnt;
   logic [31:0] div;
   logic [11:0] frame;
   logic [7:0] tw;

   assign div = bit_clks(rate);
   assign tx_start = tx_pend && tx_state == TSP_TX_IDLE && line_own;
   assign tx_done = tx_state == TSP_TX_SHIFT && tx_cnt == 32'd0 && tx_left == 4'd1;
   assign txd_out = tx_sh[0];
   always_comb begin
      tw = word_of(tx_hold, ctrl);
      frame = 12'hfff;
      frame[0] = 1'b0;
      frame[7:1] = tw[6:0];
      if (ctrl[`TSP_CTRL_DATA8]) begin
         frame[8] = tw[7];
      end
      if (ctrl[`TSP_CTRL_CHKEN]) begin
         frame[frame_len(ctrl) - 4'd2] = par_of(tw, ctrl);
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tx_state <= TSP_TX_IDLE;
         tx_sh <= 12'hfff;
         tx_left <= 4'd0;
         tx_cnt <= 32'd0;
         tx_char <= 8'h00;
      end else if (ce_in) begin
         unique case (tx_state)
            TSP_TX_IDLE: begin
               if (tx_start) begin
                  tx_sh <= frame;
                  tx_char <= tw;
                  tx_left <= 4'(frame_len(ctrl) + {3'd0, ctrl[`TSP_CTRL_STOP2]});
                  tx_cnt <= div - 32'd1;
                  tx_state <= TSP_TX_SHIFT;
               end
            end
            TSP_TX_SHIFT: begin
               if (tx_cnt != 32'd0) begin
                  tx_cnt <= tx_cnt - 32'd1;
               end else begin
                  tx_sh <= {1'b1, tx_sh[11:1]};
                  tx_left <= tx_left - 4'd1;
                  tx_cnt <= div - 32'd1;
                  if (tx_left == 4'd1) begin
                     tx_state <= TSP_TX_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // ****************************************
   // Receiver
   // ****************************************
   logic rx_m;
   logic rx_s;
   logic [11:0] rx_bits;
   logic [3:0] rx_idx;
   logic [31:0] rx_cnt;
   tsp_rx_state_t rx_state;
   logic [3:0] plen;

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rx_m <= 1'b1;
         rx_s <= 1'b1;
      end else if (ce_in) begin
         rx_m <= rxd_in;
         rx_s <= rx_m;
      end
   end

   assign plen = frame_len(ctrl);
   assign rx_done = rx_state == TSP_RX_BITS && rx_cnt == 32'd0 && rx_idx == plen - 4'd1;
   always_comb begin
      rx_word = {ctrl[`TSP_CTRL_DATA8] & rx_bits[8], rx_bits[7:1]};
      rx_perr = ctrl[`TSP_CTRL_CHKEN] && (rx_bits[plen - 4'd2] != par_of(rx_word, ctrl));
      rx_ferr = ~rx_s;
   end
   // The line is sampled once at mid-bit; a start glitch shorter than half a bit is dropped, other glitches are not filtered.
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rx_state <= TSP_RX_IDLE;
         rx_bits <= 12'h000;
         rx_idx <= 4'd0;
         rx_cnt <= 32'd0;
      end else if (ce_in) begin
         unique case (rx_state)
            TSP_RX_IDLE: begin
               if (!rx_s) begin
                  rx_cnt <= {1'b0, div[31:1]};
                  rx_state <= TSP_RX_START;
               end
            end
            TSP_RX_START: begin
               if (rx_cnt != 32'd0) begin
                  rx_cnt <= rx_cnt - 32'd1;
               end else if (!rx_s) begin
                  rx_idx <= 4'd1;
                  rx_cnt <= div - 32'd1;
                  rx_state <= TSP_RX_BITS;
               end else begin
                  rx_state <= TSP_RX_IDLE;
               end
            end
            TSP_RX_BITS: begin
               if (rx_cnt != 32'd0) begin
                  rx_cnt <= rx_cnt - 32'd1;
               end else begin
                  rx_bits[rx_idx] <= rx_s;
                  rx_idx <= rx_idx + 4'd1;
                  rx_cnt <= div - 32'd1;
                  if (rx_done) begin
                     rx_state <= TSP_RX_IDLE;
                  end
               end
            end
         endcase
      end
   end
   // A new character or echo in the cycle of an RXDATA read keeps its flags set.
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rx_data <= 8'h00;
         rx_valid <= 1'b0;
         par_err <= 1'b0;
         frm_err <= 1'b0;
      end else if (ce_in) begin
         if (rx_done) begin
            rx_data <= rx_word;
            rx_valid <= 1'b1;
            par_err <= rx_perr;
            frm_err <= rx_ferr;
         end else if (tx_start && ctrl[`TSP_CTRL_HALF]) begin
            rx_data <= tw;
            rx_valid <= 1'b1;
            par_err <= 1'b0;
            frm_err <= 1'b0;
         end else if (rd_rx) begin
            rx_valid <= 1'b0;
            par_err <= 1'b0;
            frm_err <= 1'b0;
         end
      end
   end

endmodule

/* File: verif/tsp_port_properties.sv */
// Checker of the serial port's bus answers and line timing.
`timescale 1ns/1ps
// ****
// Port checker
// ****
module tsp_port_checker #(
   parameter int CLK_HZ = 192000
) (
   // Watched ports
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire tsp_pkg::tsp_addr_t paddr_in,
   input wire tsp_pkg::tsp_word_t pwdata_in,
   input wire tsp_pkg::tsp_word_t prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   input wire logic txd_out,
   input wire logic rts_out
);
   import tsp_pkg::*;
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   sequence s_ctrl_wr;
      pready_out && pwrite_in && paddr_in == 12'h000;
   endsequence
   property p_ready; pready_out == (psel_in && penable_in && ce_in); endproperty
   property p_err; pslverr_out |-> pready_out; endproperty
   property p_unmapped;
      pready_out && paddr_in > 12'h010 |-> pslverr_out && prdata_out == 32'h0;
   endproperty
   // Every bit lasts at least ten clocks at the fastest rate used here.
   property p_start; $fell(txd_out) |-> !txd_out [*8]; endproperty
   property p_mark; $rose(txd_out) |-> txd_out [*8]; endproperty
   property p_idle; $rose(rst_n_in) |-> txd_out && !rts_out; endproperty
   property p_fdx; s_ctrl_wr ##0 pwdata_in[8:6] == 3'b010 |-> ##2 rts_out; endproperty
   property p_none; s_ctrl_wr ##0 pwdata_in[8:6] == 3'b000 |-> ##2 !rts_out [*2]; endproperty
   a_ready: assert property (p_ready) else $error("pready does not follow access phase");
   a_err: assert property (p_err) else $error("error without ready");
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
   a_start: assert property (p_start) else $error("start or data zero too short");
   a_mark: assert property (p_mark) else $error("mark bit too short");
   a_idle: assert property (p_idle) else $error("line not idle after reset");
   a_fdx: assert property (p_fdx) else $error("rts not held high");
   a_none: assert property (p_none) else $error("rts not held low");
endmodule
bind tsp_serial_port tsp_port_checker #(.CLK_HZ(CLK_HZ)) i_chk (.clk_sys_in(clk_sys_in),
   .rst_n_in(rst_n_in), .ce_in(ce_in), .psel_in(psel_in), .penable_in(penable_in),
   .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
   .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
   .txd_out(txd_out), .rts_out(rts_out));

/* File: verif/tsp_host_model.sv */
// Behavioural host at the far end of the serial line.
`timescale 1ns/1ps
// ****
// Host model
// ****
module tsp_host_model (
   // Clock, line and frame shape
   input wire logic clk_sys_in,
   input wire logic txd_in,
   input int n_bits_in,
   input int bit_clks_in,
   output logic rxd_out,
   output logic sec_out
);
   logic [11:0] got[$];
   logic [11:0] cap;
   initial begin
      rxd_out = 1'b1;
      sec_out = 1'b0;
   end
   // Mid-bit sampling, so a wrong bit time shifts the captured pattern.
   always begin
      @(negedge txd_in);
      cap = 12'hfff;
      repeat (bit_clks_in / 2) @(posedge clk_sys_in);
      for (int k = 0; k < n_bits_in; k++) begin
         cap[k] = txd_in;
         repeat (bit_clks_in) @(posedge clk_sys_in);
      end
      got.push_back(cap);
   end
   task automatic send(input logic [11:0] f, input int n);
      for (int k = 0; k < n; k++) begin
         rxd_out <= f[k];
         repeat (bit_clks_in) @(posedge clk_sys_in);
      end
      rxd_out <= 1'b1;
   endtask
   task automatic hold(input logic v);
      sec_out <= v;
   endtask
endmodule

/* File: verif/testbench.sv */
// Self-checking bench of the serial port.
`timescale 1ns/1ps
// ****
// Bench
// ****
module testbench;
   import tsp_pkg::*;
   localparam int CLK_HZ = 192000;
   logic clk_sys_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   tsp_addr_t paddr = '0;
   tsp_word_t pwdata = '0;
   tsp_word_t prdata;
   logic pready, perr, rxd, sec, txd, rts;
   logic sec_tx;
   logic ce = 1'b1;
   int n_bits = 9;
   int bc = 10;
   int failures = 0;
   int n_compared = 0;
   logic [31:0] seed = 32'h664;
   tsp_serial_port #(.CLK_HZ(CLK_HZ)) i_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
      .ce_in(ce), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
      .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr),
      .rxd_in(rxd), .sec_rx_in(sec), .txd_out(txd), .rts_out(rts), .sec_tx_out(sec_tx));
   tsp_host_model i_host (.clk_sys_in(clk_sys_in), .txd_in(txd), .n_bits_in(n_bits),
      .bit_clks_in(bc), .rxd_out(rxd), .sec_out(sec));
   always #5 clk_sys_in = ~clk_sys_in;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [7:0] word(input logic [11:0] c, input logic [7:0] d);
      return {c[0] & c[1], d[6:0]};
   endfunction
   function automatic logic [11:0] frame(input logic [11:0] c, input logic [7:0] d,
         output int n);
      logic [7:0] w;
      w = word(c, d);
      frame = 12'hffe;
      for (int k = 0; k < 7 + c[0]; k++) frame[k + 1] = w[k];
      n = 8 + c[0];
      if (c[2]) begin
         frame[n] = ^w ^ c[3];
         n++;
      end
      n += 1 + c[4];
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
      n_compared++;
      if (g !== x) begin
         failures++;
         $display("ERROR %0t %s got %h exp %h", $time, m, g, x);
      end
   endtask
   // The master waits for ready without assuming a latency.
   task automatic apb(input logic w, input tsp_addr_t a, input tsp_word_t d,
         output tsp_word_t r, output logic e);
      int i;
      i = 0;
      @(posedge clk_sys_in);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys_in);
      pen <= 1'b1;
      do begin
         @(posedge clk_sys_in);
         i++;
      end while (pready !== 1'b1 && i < 50);
      chk(i < 50, 1, "no ready");
      r = prdata;
      e = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic wr(input tsp_addr_t a, input tsp_word_t d);
      tsp_word_t r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd(input tsp_addr_t a, input tsp_word_t k, input tsp_word_t x,
         input string m);
      tsp_word_t r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r & k, x, m);
   endtask
   task automatic frame_out(input logic [11:0] x);
      int i;
      i = 0;
      while (i_host.got.size() == 0 && i < 2000) begin
         @(posedge clk_sys_in);
         i++;
      end
      chk(i_host.got.size() > 0 ? i_host.got.pop_front() : 12'h0, x, "frame");
   endtask
   task automatic end_sim();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clk_sys_in);
      failures++;
      end_sim();
   end
   initial begin
      logic [11:0] c, f;
      logic [7:0] d;
      int n;
      tsp_word_t rw;
      logic e;
      repeat (6) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      rd(12'h000, 32'hffffffff, 32'h0, "ctrl reset");
      rd(12'h004, 32'hffffffff, 32'h8, "rate reset");
      rd(12'h010, 32'h20, 32'h20, "line owned");
      apb(1'b0, 12'h014, 32'h0, rw, e);
      chk(rw, 0, "unmapped data");
      chk(e, 1, "unmapped error");
      $display("test reset done");
      for (int t = 0; t < 12; t++) begin
         rw = rnd();
         c = 12'h040 | {6'h0, rw[5:0]};
         bc = CLK_HZ / (2400 << rw[9:8]);
         wr(12'h004, 32'h80 << rw[9:8]);
         wr(12'h000, {20'h0, c});
         d = rw[23:16];
         f = frame(c, d, n);
         n_bits = n;
         wr(12'h008, {24'h0, d});
         repeat (n * bc - bc / 2) @(posedge clk_sys_in);
         chk(rts, 1, "rts in last stop bit");
         frame_out(f);
         repeat (bc + 3) @(posedge clk_sys_in);
         chk(rts, 0, "rts after frame");
         rd(12'h010, 32'h1, {31'h0, c[5]}, "echo flag");
         if (c[5]) rd(12'h00c, 32'hff, {24'h0, word(c, d)}, "echo data");
         d = rw[31:24];
         f = frame(c, d, n);
         i_host.send(f, n);
         repeat (2) @(posedge clk_sys_in);
         rd(12'h010, 32'h7, 32'h1, "rx status");
         rd(12'h00c, 32'hff, {24'h0, word(c, d)}, "rx data");
      end
      $display("test frames done");
      c = 12'h04c;
      wr(12'h000, {20'h0, c});
      f = frame(c, 8'h55, n) ^ 12'h300;
      i_host.send(f, n);
      repeat (2) @(posedge clk_sys_in);
      rd(12'h010, 32'h7, 32'h7, "rx errors");
      rd(12'h00c, 32'hff, 32'h55, "rx bad data");
      wr(12'h000, 32'h080);
      repeat (3) @(posedge clk_sys_in);
      chk(rts, 1, "fdx modem rts");
      wr(12'h000, 32'h000);
      repeat (3) @(posedge clk_sys_in);
      chk(rts, 0, "no method rts");
      for (int k = 0; k < 2; k++) begin
         c = 12'h300 | (12'h400 << k);
         wr(12'h000, {20'h0, c});
         f = frame(c, 8'h03 + k, n);
         n_bits = n;
         wr(12'h008, 32'h03 + k);
         frame_out(f);
         repeat (bc + 3) @(posedge clk_sys_in);
         rd(12'h010, 32'h60, 32'h0, "line given away");
         wr(12'h008, 32'h41);
         repeat (4 * bc) @(posedge clk_sys_in);
         chk(i_host.got.size(), 0, "sent while remote owns");
         i_host.send(f, n);
         f = frame(c, 8'h41, n);
         frame_out(f);
         rd(12'h00c, 32'hff, 32'h03 + k, "code received");
      end
      wr(12'h000, 32'h100);
      i_host.hold(1'b1);
      repeat (5) @(posedge clk_sys_in);
      rd(12'h010, 32'h60, 32'h0, "remote holds");
      chk(sec_tx, 1, "our channel released");
      i_host.hold(1'b0);
      repeat (5) @(posedge clk_sys_in);
      rd(12'h010, 32'h60, 32'h60, "line back");
      chk(sec_tx, 0, "our channel held");
      ce <= 1'b0;
      fork
         rd(12'h010, 32'h60, 32'h60, "read across freeze");
         begin
            repeat (5) @(posedge clk_sys_in);
            chk(pready, 0, "ready while frozen");
            ce <= 1'b1;
         end
      join
      $display("test modes done");
      end_sim();
   end
endmodule
